// ==== obcd_pkg.sv ====
// Package with option byte field layout, codes and timing counts for the option decoder.
package obcd_pkg;

   // ***************************************
   // Option byte 0 field positions
   // ***************************************
   localparam int OB0_CLK_SEC_BIT  = 5;
   localparam int OB0_VSEL_HI      = 4;
   localparam int OB0_VSEL_LO      = 3;
   localparam int OB0_PKG_LO_BIT   = 1;
   localparam int OB0_PROT_BIT     = 0;

   // ***************************************
   // Option byte 1 field positions
   // ***************************************
   localparam int OB1_PKG_HI_BIT   = 7;
   localparam int OB1_RCYC_BIT     = 6;
   localparam int OB1_TYPE_HI      = 5;
   localparam int OB1_TYPE_LO      = 4;
   localparam int OB1_RANGE_HI     = 3;
   localparam int OB1_RANGE_LO     = 1;
   localparam int OB1_DBL_BIT      = 0;

   // ***************************************
   // Reset values and codes
   // ***************************************
   localparam logic [7:0] OB_ERASED        = 8'hff;
   localparam logic [1:0] VSEL_OFF         = 2'h3;
   localparam logic [1:0] VSEL_HIGHEST     = 2'h0;
   localparam logic [2:0] RANGE_1_2        = 3'h0;
   localparam logic [2:0] RANGE_2_4        = 3'h1;
   localparam logic [2:0] RANGE_4_8        = 3'h2;
   localparam logic [2:0] RANGE_8_16       = 3'h3;
   localparam int         PADS_PER_PORT    = 8;

   // ***************************************
   // Timing counts in CPU cycles
   // ***************************************
   localparam logic [12:0] RST_CYC_LONG    = 13'h1000;
   localparam logic [12:0] RST_CYC_SHORT   = 13'h0100;

   typedef enum logic [1:0] {
      OBCD_SRC_RESONATOR,
      OBCD_SRC_EXT_RC,
      OBCD_SRC_INT_RC,
      OBCD_SRC_EXT_CLOCK
   } obcd_src_e;

   typedef enum logic [1:0] {
      OBCD_PKG_80,
      OBCD_PKG_64,
      OBCD_PKG_NONE
   } obcd_pkg_e;

   typedef struct packed {
      logic        low_voltage_reset_monitor;
      logic        aux_voltage_warning;
      logic        highest_threshold;
      logic        vsel_code_unused;
   } obcd_volt_s;

   typedef struct packed {
      obcd_src_e   clock_source_type;
      logic [2:0]  clock_freq_range;
      logic        clock_security;
      logic        doubler_en;
      logic        range_unused;
   } obcd_clk_s;

endpackage

// ==== obcd_delay.sv ====
// Reset phase and halt exit delay counter.
`timescale 1ns/1ps
module obcd_delay
   import obcd_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        start_i,
   input  wire logic        short_sel_i,
   input  wire logic        main_osc_ready_i,
   input  wire logic        clock_security_i,
   output logic             busy_o
);

   logic [12:0] count_r;
   logic        run_r;
   logic [12:0] limit;

   assign limit  = short_sel_i ? RST_CYC_SHORT : RST_CYC_LONG;
   assign busy_o = run_r;

   // ***************************************
   // Counting
   // ***************************************
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         count_r <= 13'h0000;
         run_r   <= 1'b0;
      end else if (start_i) begin
         count_r <= 13'h0000;
         run_r   <= 1'b1;
      end else if (run_r && (clock_security_i || main_osc_ready_i)) begin
         if (count_r == limit - 13'h0001) begin
            run_r <= 1'b0;
         end
         count_r <= count_r + 13'h0001;
      end
   end

endmodule

// ==== obcd_top.sv ====
// Option byte configuration decoder top level.
// Operation
// - Voltage field: 11 both detectors off, 00 highest threshold, others unused.
// - Protection bit 0 blocks flash read and write in test and programming modes.
// - Protected option byte erase first erases all user memory.
// - Package bits 11 select 80 pins, 10 select 64 pins.
// - Unbonded pads stay input pull-up after reset.
// - Reset cycle bit: 0 gives 4096 cycles, 1 gives 256 cycles.
// - With clock security on, delay counts at once on backup oscillator.
// - Clock type: resonator, external RC, internal RC, external clock.
// - Range field picks resonator drive or operating frequency range.
// - Doubler bit 0 enables times two, 1 bypasses it.
`timescale 1ns/1ps
module obcd_top
   import obcd_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  option_byte0_i,
   input  wire logic [7:0]  option_byte1_i,
   input  wire logic        test_mode_i,
   input  wire logic        in_circuit_programming_i,
   input  wire logic        flash_rd_req_i,
   input  wire logic        flash_wr_req_i,
   input  wire logic        opt_erase_req_i,
   input  wire logic        user_erase_done_i,
   input  wire logic        main_osc_ready_i,
   input  wire logic        halt_exit_i,
   output obcd_volt_s       volt_o,
   output obcd_clk_s        clk_o,
   output logic             readout_protect_o,
   output logic             flash_rd_allow_o,
   output logic             flash_wr_allow_o,
   output logic             user_erase_req_o,
   output logic             opt_erase_go_o,
   output obcd_pkg_e        package_o,
   output logic             package_sel_lo_o,
   output logic             package_sel_hi_o,
   output logic [PADS_PER_PORT-1:0] pad_pullup_o,
   output logic             reset_cycle_count_sel_o,
   output logic             cpu_hold_o
);

   typedef enum logic [1:0] {
      OBCD_ER_IDLE,
      OBCD_ER_USER,
      OBCD_ER_OPT
   } obcd_er_e;

   logic [7:0] ob0_r;
   logic [7:0] ob1_r;
   logic       load_r;
   logic       start_r;
   logic       busy;
   obcd_er_e   er_r;
   logic       locked;
   logic [1:0] vsel;

   // ***************************************
   // Option byte capture
   // ***************************************
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ob0_r  <= OB_ERASED;
         ob1_r  <= OB_ERASED;
         load_r <= 1'b1;
      end else if (load_r) begin
         ob0_r  <= option_byte0_i;
         ob1_r  <= option_byte1_i;
         load_r <= 1'b0;
      end
   end

   // ***************************************
   // Voltage detector decode
   // ***************************************
   assign vsel = ob0_r[OB0_VSEL_HI:OB0_VSEL_LO];

   always_comb begin
      volt_o.low_voltage_reset_monitor = (vsel != VSEL_OFF);
      volt_o.aux_voltage_warning       = (vsel != VSEL_OFF);
      volt_o.highest_threshold         = (vsel == VSEL_HIGHEST);
      volt_o.vsel_code_unused          = ~volt_o.highest_threshold
                                         & volt_o.low_voltage_reset_monitor;
   end

   // ***************************************
   // Clock decode
   // ***************************************
   always_comb begin
      clk_o.clock_source_type = obcd_src_e'(ob1_r[OB1_TYPE_HI:OB1_TYPE_LO]);
      clk_o.clock_freq_range  = ob1_r[OB1_RANGE_HI:OB1_RANGE_LO];
      clk_o.clock_security    = ~ob0_r[OB0_CLK_SEC_BIT];
      clk_o.doubler_en        = ~ob1_r[OB1_DBL_BIT];
      clk_o.range_unused      = (ob1_r[OB1_RANGE_HI:OB1_RANGE_LO] > RANGE_8_16);
   end

   // ***************************************
   // Read-out protection and erase order
   // ***************************************
   assign readout_protect_o = ~ob0_r[OB0_PROT_BIT];
   assign locked            = readout_protect_o & (test_mode_i | in_circuit_programming_i);
   assign flash_rd_allow_o  = flash_rd_req_i & ~locked;
   assign flash_wr_allow_o  = flash_wr_req_i & ~locked;
   assign user_erase_req_o  = (er_r == OBCD_ER_USER);
   assign opt_erase_go_o    = (er_r == OBCD_ER_OPT);

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         er_r <= OBCD_ER_IDLE;
      end else begin
         case (er_r)
            OBCD_ER_IDLE: begin
               if (opt_erase_req_i) begin
                  er_r <= readout_protect_o ? OBCD_ER_USER : OBCD_ER_OPT;
               end
            end
            OBCD_ER_USER: begin
               if (user_erase_done_i) begin
                  er_r <= OBCD_ER_OPT;
               end
            end
            default: begin
               er_r <= OBCD_ER_IDLE;
            end
         endcase
      end
   end

   // ***************************************
   // Package selection and pads
   // ***************************************
   assign package_sel_lo_o = ob0_r[OB0_PKG_LO_BIT];
   assign package_sel_hi_o = ob1_r[OB1_PKG_HI_BIT];

   always_comb begin
      if (package_sel_hi_o && package_sel_lo_o) begin
         package_o = OBCD_PKG_80;
      end else if (package_sel_hi_o) begin
         package_o = OBCD_PKG_64;
      end else begin
         package_o = OBCD_PKG_NONE;
      end
   end

   for (genvar i = 0; i < PADS_PER_PORT; i++) begin : g_pad
      assign pad_pullup_o[i] = 1'b1;
   end

   // ***************************************
   // Reset phase and halt exit delay
   // ***************************************
   assign reset_cycle_count_sel_o = ob1_r[OB1_RCYC_BIT];

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         start_r <= 1'b0;
      end else begin
         start_r <= load_r | halt_exit_i;
      end
   end

   obcd_delay u_delay (
      .clock_i          (clock_i),
      .rst_i            (rst_i),
      .start_i          (start_r),
      .short_sel_i      (reset_cycle_count_sel_o),
      .main_osc_ready_i (main_osc_ready_i),
      .clock_security_i (clk_o.clock_security),
      .busy_o           (busy)
   );

   assign cpu_hold_o = busy | load_r | start_r;

endmodule

// ==== obcd_checker.sv ====
// Concurrent checks on the option byte decoder ports.
`timescale 1ns/1ps
module obcd_checker
   import obcd_pkg::*;
(
   input wire logic       clock_i,
   input wire logic       rst_i,
   input wire logic       test_mode_i,
   input wire logic       in_circuit_programming_i,
   input wire logic       flash_rd_req_i,
   input wire logic       flash_wr_req_i,
   input wire logic       user_erase_done_i,
   input wire obcd_volt_s volt_o,
   input wire obcd_clk_s  clk_o,
   input wire logic       readout_protect_o,
   input wire logic       flash_rd_allow_o,
   input wire logic       flash_wr_allow_o,
   input wire logic       user_erase_req_o,
   input wire logic       opt_erase_go_o,
   input wire obcd_pkg_e  package_o,
   input wire logic       reset_cycle_count_sel_o,
   input wire logic       cpu_hold_o
);
   logic [12:0] hold_cnt_r;
   logic        lock;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   assign lock = readout_protect_o && (test_mode_i || in_circuit_programming_i);
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) hold_cnt_r <= 13'h0;
      else hold_cnt_r <= cpu_hold_o ? hold_cnt_r + 13'h1 : 13'h0;
   end
   property p_rd; flash_rd_allow_o == (flash_rd_req_i && !lock); endproperty
   a_rd: assert property (p_rd) else $error("read gate wrong");
   property p_wr; flash_wr_allow_o == (flash_wr_req_i && !lock); endproperty
   a_wr: assert property (p_wr) else $error("write gate wrong");
   property p_vsel;
      volt_o.highest_threshold |-> volt_o.low_voltage_reset_monitor && volt_o.aux_voltage_warning;
   endproperty
   a_vsel: assert property (p_vsel) else $error("detectors off at highest level");
   property p_ureq; user_erase_req_o |-> readout_protect_o; endproperty
   a_ureq: assert property (p_ureq) else $error("user erase while open");
   property p_go; opt_erase_go_o && readout_protect_o |-> $past(user_erase_done_i); endproperty
   a_go: assert property (p_go) else $error("erase before user memory");
   property p_pulse; opt_erase_go_o |=> !opt_erase_go_o; endproperty
   a_pulse: assert property (p_pulse) else $error("erase go too long");
   property p_keep;
      !$past(rst_i) && !$past(rst_i, 2) |-> $stable(volt_o) && $stable(clk_o)
         && $stable(readout_protect_o) && $stable(package_o);
   endproperty
   a_keep: assert property (p_keep) else $error("decode changed");
   property p_len;
      clk_o.clock_security |-> hold_cnt_r <= (reset_cycle_count_sel_o ? 13'h0104 : 13'h1004);
   endproperty
   a_len: assert property (p_len) else $error("hold too long");
   property p_rng; clk_o.range_unused == (clk_o.clock_freq_range > 3'h3); endproperty
   a_rng: assert property (p_rng) else $error("range flag wrong");
   c_go: cover property (opt_erase_go_o && readout_protect_o);
   c_lock: cover property (flash_rd_req_i && lock);
   c_hold: cover property ($fell(cpu_hold_o) && clk_o.clock_security);
endmodule

// ==== obcd_far_model.sv ====
// Far side model: option byte store, oscillator start-up, user memory eraser.
`timescale 1ns/1ps
module obcd_far_model #(
   parameter int OSC_DLY = 40,
   parameter int ERASE_DLY = 20
) (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       prog_i,
   input  wire logic [7:0] prog_b0_i,
   input  wire logic [7:0] prog_b1_i,
   input  wire logic       user_erase_req_i,
   output logic [7:0]      option_byte0_o,
   output logic [7:0]      option_byte1_o,
   output logic            main_osc_ready_o,
   output logic            user_erase_done_o
);
   int osc_cnt = 0;
   int er_cnt = 0;
   initial option_byte0_o = 8'hff;
   initial option_byte1_o = 8'hff;
   always @(posedge clock_i) begin
      if (prog_i) begin
         option_byte0_o <= prog_b0_i;
         option_byte1_o <= prog_b1_i;
      end
   end
   always @(posedge clock_i or posedge rst_i) begin
      if (rst_i) osc_cnt <= 0;
      else if (osc_cnt < OSC_DLY) osc_cnt <= osc_cnt + 1;
   end
   always @(posedge clock_i) begin
      if (!user_erase_req_i) er_cnt <= 0;
      else if (er_cnt <= ERASE_DLY) er_cnt <= er_cnt + 1;
   end
   assign main_osc_ready_o = (osc_cnt == OSC_DLY);
   assign user_erase_done_o = (er_cnt == ERASE_DLY);
endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the option byte decoder.
`timescale 1ns/1ps
module tb_top;
   import obcd_pkg::*;
   logic       clock_i = 0, rst_i = 1, tm = 0, prg = 0, rd = 0, wr = 0;
   logic       er = 0, hx = 0, prog = 0, osc, done, uer, go, prot, rda, wra, rsel, hold;
   logic       psl, psh;
   logic [7:0] pb0 = 8'hff, pb1 = 8'hff, ob0, ob1, pads;
   obcd_volt_s volt;
   obcd_clk_s  clk;
   obcd_pkg_e  pkg;
   int         err_total = 0, check_count = 0, cyc = 0;
   always #5 clock_i = ~clock_i;
   obcd_far_model obcd_far_model_inst (.clock_i, .rst_i, .prog_i(prog), .prog_b0_i(pb0),
      .prog_b1_i(pb1), .user_erase_req_i(uer), .option_byte0_o(ob0), .option_byte1_o(ob1),
      .main_osc_ready_o(osc), .user_erase_done_o(done));
   obcd_top obcd_top_inst (.clock_i, .rst_i, .option_byte0_i(ob0), .option_byte1_i(ob1),
      .test_mode_i(tm), .in_circuit_programming_i(prg), .flash_rd_req_i(rd),
      .flash_wr_req_i(wr), .opt_erase_req_i(er), .user_erase_done_i(done),
      .main_osc_ready_i(osc), .halt_exit_i(hx), .volt_o(volt), .clk_o(clk),
      .readout_protect_o(prot), .flash_rd_allow_o(rda), .flash_wr_allow_o(wra),
      .user_erase_req_o(uer), .opt_erase_go_o(go), .package_o(pkg), .package_sel_lo_o(psl),
      .package_sel_hi_o(psh), .pad_pullup_o(pads), .reset_cycle_count_sel_o(rsel),
      .cpu_hold_o(hold));
   task give_verdict;
      $display("Checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [15:0] g, input int e);
      check_count++;
      if (g !== 16'(e)) begin
         err_total++;
         $display("Error %0t: got %h expected %0h", $time, g, e);
      end
   endtask
   task boot(input logic [7:0] b0, b1, input int win, output int n);
      @(negedge clock_i); {pb0, pb1, prog} = {b0, b1, 1'b1};
      @(negedge clock_i); {prog, rst_i} = 2'h1;
      repeat (4) @(negedge clock_i);
      {rst_i, n} = 0;
      repeat (win) begin @(negedge clock_i); n += hold; end
   endtask
   task t_cfg(input logic [7:0] b0, b1);
      int n, len, ex;
      len = b1[6] ? 256 : 4096;
      ex = b0[5] ? 40 : 0;
      boot(b0, b1, len + 60, n);
      chk(volt.low_voltage_reset_monitor, b0[4:3] != 2'h3);
      chk(volt.highest_threshold, b0[4:3] == 2'h0);
      chk(volt.aux_voltage_warning, b0[4:3] != 2'h3);
      chk(volt.vsel_code_unused, b0[4:3] == 2'h1 || b0[4:3] == 2'h2);
      chk(prot, !b0[0]);
      chk(pkg, b1[7] ? (b0[1] ? 0 : 1) : 2);
      chk(psl, b0[1]);
      chk(psh, b1[7]);
      chk(pads, 8'hff);
      chk(rsel, b1[6]);
      chk(n inside {[len + ex - 3 : len + ex + 4]}, 1);
      chk(clk.clock_security, !b0[5]);
      chk(clk.clock_source_type, b1[5:4]);
      chk(clk.clock_freq_range, b1[3:1]);
      chk(clk.range_unused, b1[3:1] > 3'h3);
      chk(clk.doubler_en, !b1[0]);
      $display("Config test %h %h done", b0, b1);
   endtask
   task t_flash(input logic p);
      for (int m = 0; m < 4; m++) begin
         @(negedge clock_i); {tm, prg, rd, wr} = {m[1:0], 2'h3};
         #1 chk(rda, m == 0 || !p);
         chk(wra, m == 0 || !p);
      end
      @(negedge clock_i); {tm, prg, rd, wr} = 4'h0;
      $display("Flash gate test done");
   endtask
   task t_erase(input logic p);
      int k;
      @(negedge clock_i); er = 1;
      @(negedge clock_i); {er, k} = 0;
      chk(uer, p);
      while (go !== 1'b1 && k < 100) begin @(negedge clock_i); k++; end
      chk(go, 1);
      chk(k > 15, p);
      @(negedge clock_i); chk(go, 0);
      $display("Erase test done");
   endtask
   task t_halt_keep;
      int n;
      @(negedge clock_i); {hx, pb0, pb1, prog, n} = {1'b1, 16'hc482, 1'b1, 32'h0};
      @(negedge clock_i); {hx, prog} = 2'h0;
      repeat (316) begin @(negedge clock_i); n += hold; end
      chk(n inside {[252:259]}, 1);
      chk(prot, 0);
      chk(clk.clock_source_type, 1);
      $display("Halt exit and hold test done");
   endtask
   initial begin
      t_cfg(8'hff, 8'hff);
      t_cfg(8'hc4, 8'h82);
      t_flash(1);
      t_erase(1);
      t_cfg(8'hf7, 8'hd7);
      t_flash(0);
      t_erase(0);
      t_halt_keep;
      t_cfg(8'hcd, 8'h61);
      t_cfg(8'hde, 8'hf5);
      t_cfg(8'hfe, 8'hf9);
      give_verdict;
   end
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         give_verdict;
      end
   end
endmodule
bind obcd_top obcd_checker obcd_checker_inst (.clock_i, .rst_i, .test_mode_i,
   .in_circuit_programming_i, .flash_rd_req_i, .flash_wr_req_i, .user_erase_done_i, .volt_o,
   .clk_o, .readout_protect_o, .flash_rd_allow_o, .flash_wr_allow_o, .user_erase_req_o,
   .opt_erase_go_o, .package_o, .reset_cycle_count_sel_o, .cpu_hold_o);
